/* hw/ccr_pkg.sv */
package ccr_pkg;
    // Register offsets (SMBus command codes)
    localparam logic [7:0] OFS_CTRL5 = 8'h38;
    localparam logic [7:0] OFS_CTRL3 = 8'h4c;
    localparam logic [7:0] OFS_CTRL4 = 8'h4e;

    // Control_three_dither_alert_sources field positions
    localparam int C3_DITHER_LO  = 14;
    localparam int C3_ADP_DIS    = 13;
    localparam int C3_SYS_SINK   = 12;
    localparam int C3_GATE_TRI   = 11;
    localparam int C3_T3_SHORT   = 10;
    localparam int C3_T2_NORMAL  = 9;
    localparam int C3_SRC_OVC    = 7;
    localparam int C3_SRC_BATABS = 6;
    localparam int C3_SRC_ADP    = 5;
    localparam int C3_SRC_CMP    = 4;
    localparam int C3_DEB_LO     = 2;
    // Control_four_alert_clear_latch field positions
    localparam int C4_CLEAR      = 1;
    localparam int C4_LATCH      = 0;
    // Control_five_timers_protection field positions
    localparam int C5_COMP_LO    = 14;
    localparam int C5_FORCE_GATE = 13;
    localparam int C5_REV_REG    = 11;
    localparam int C5_T2_LO      = 8;
    localparam int C5_CMP_DIS    = 7;
    localparam int C5_SRC_DIS    = 6;
    localparam int C5_PIN_SEL    = 5;
    localparam int C5_OV_DIS     = 4;
    localparam int C5_T1_LO      = 0;

    // Writable bit masks; other bits read zero
    localparam logic [15:0] MASK_CTRL3 = 16'hfefc;
    localparam logic [15:0] MASK_CTRL4 = 16'h0003;
    localparam logic [15:0] MASK_CTRL5 = 16'heff7;
    // Power-on values
    localparam logic [15:0] RST_CTRL3 = 16'h0000;
    localparam logic [15:0] RST_CTRL4 = 16'h0000;
    localparam logic [15:0] RST_CTRL5 = 16'h0000;

    // Debounce times in ns, clock period in ns
    localparam int CLK_NS   = 10;
    localparam int DEB0_NS  = 2000;
    localparam int DEB1_NS  = 25000;
    localparam int DEB2_NS  = 125000;
    localparam int DEB3_NS  = 250000;
    localparam int DEB0_CYC = (DEB0_NS + CLK_NS - 1) / CLK_NS;
    localparam int DEB1_CYC = (DEB1_NS + CLK_NS - 1) / CLK_NS;
    localparam int DEB2_CYC = (DEB2_NS + CLK_NS - 1) / CLK_NS;
    localparam int DEB3_CYC = (DEB3_NS + CLK_NS - 1) / CLK_NS;

    // Alert source flags
    typedef struct packed {
        logic reverse_overcurrent_flag;
        logic battery_absent_flag;
        logic adapter_present_flag;
        logic comparator_rise;
    } ccr_flags_t;

    // Decoded analog controls
    typedef struct packed {
        logic [1:0] dither_sel;
        logic       adapter_node_sink_en;
        logic       system_rail_sink_en;
        logic       battery_switch_gate_hiz;
        logic       t3_short;
        logic       t2_dcm_normal;
        logic [1:0] comp_res_sel;
        logic       battery_switch_gate_force;
        logic       reverse_reg_en;
        logic [2:0] second_level_adapter_limit_sel;
        logic [2:0] first_level_adapter_limit_sel;
        logic       system_rail_good_cmp_en;
        logic       system_rail_good_src_en;
        logic       pin_sel_comparator;
        logic       overvoltage_prot_en;
    } ccr_ctrl_t;
endpackage

/* hw/ccr_regs.sv */
// Behaviour
// RQ1: Dither code off, or 2/4/6 percent spread
// RQ2: Bit 13 enables adapter node sink
// RQ3: Bit 12 enables system rail sink
// RQ4: Bit 11 tri-states battery switch gate
// RQ5: Bit 10 selects short minimum T3
// RQ6: Bit 9 selects normal DCM T2
// RQ7: Bits 7:4 enable alert trip sources
// RQ8: Bits 3:2 set alert trip debounce
// RQ9: Writing clear bit releases asserted alert
// RQ10: Latch bit holds alert low until cleared
// RQ11: Bits 15:14 select compensation resistance
// RQ12: Bit 13 forces battery switch gate on
// RQ13: Bit 11 enables reverse battery regulation
// RQ14: Bits 10:8 select second limit time
// RQ15: Bits 2:0 select first limit time
// RQ16: Bit 7 disables rail good comparator
// RQ17: Bit 6 disables rail good source
// RQ18: Bit 5 routes comparator to pin
// RQ19: Bit 4 disables overvoltage protections
// RQ20: Registers read/write; digital reset restores defaults
// RQ21: Clear bit self-clears; unused bits read zero
`timescale 1ns/10ps
`default_nettype none
module ccr_regs #(
    parameter int DEB_W = 16
) (
    // Clock and reset
    input  wire logic                 CLK,
    input  wire logic                 RESETN,
    // Register port from SMBus engine
    input  wire logic                 REG_WR,
    input  wire logic                 REG_RD,
    input  wire logic [7:0]           REG_ADDR,
    input  wire logic [15:0]          REG_WDATA,
    output var  logic [15:0]          REG_RDATA,
    output var  logic                 REG_HIT,
    // Digital reset command
    input  wire logic                 DIG_RESET,
    // Alert sources
    input  wire ccr_pkg::ccr_flags_t  ALERT_SRC,
    // Alert pin and controls
    output var  logic                 PROCESSOR_HOT_ALERT_N,
    output var  ccr_pkg::ccr_ctrl_t   CTRL
);
    initial begin
        if (DEB_W < 15 || DEB_W > 31) begin
            $error("DEB_W cannot hold the longest debounce count");
        end
    end

    logic [15:0] ctrl3_r, ctrl4_r, ctrl5_r;
    logic [DEB_W-1:0] deb_cnt_r, deb_cnt_nxt, deb_len;
    logic alert_r, alert_nxt;

    // Address decode
    wire sel3 = (REG_ADDR == ccr_pkg::OFS_CTRL3);
    wire sel4 = (REG_ADDR == ccr_pkg::OFS_CTRL4);
    wire sel5 = (REG_ADDR == ccr_pkg::OFS_CTRL5);
    wire wr_clear = REG_WR && sel4 && REG_WDATA[ccr_pkg::C4_CLEAR]; // RQ9

    // Register writes; digital reset restores power-on values
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl3_r <= ccr_pkg::RST_CTRL3;
            ctrl4_r <= ccr_pkg::RST_CTRL4;
            ctrl5_r <= ccr_pkg::RST_CTRL5;
        end else if (DIG_RESET) begin
            ctrl3_r <= ccr_pkg::RST_CTRL3; // RQ20
            ctrl4_r <= ccr_pkg::RST_CTRL4;
            ctrl5_r <= ccr_pkg::RST_CTRL5;
        end else if (REG_WR) begin
            if (sel3) ctrl3_r <= REG_WDATA & ccr_pkg::MASK_CTRL3; // RQ21
            if (sel4) ctrl4_r <= REG_WDATA & ccr_pkg::MASK_CTRL4 &
                                 ~(16'h0001 << ccr_pkg::C4_CLEAR); // RQ21
            if (sel5) ctrl5_r <= REG_WDATA & ccr_pkg::MASK_CTRL5;
        end
    end

    // Readback; clear bit always reads idle
    assign REG_HIT = (REG_WR || REG_RD) && (sel3 || sel4 || sel5);
    wire [15:0] rd_mux = sel3 ? ctrl3_r : sel4 ? ctrl4_r : sel5 ? ctrl5_r : 16'h0000;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) REG_RDATA <= 16'h0000;
        else if (REG_RD) REG_RDATA <= rd_mux; // RQ20
    end

    // Trip sources; adapter trips on fall, battery-absent on rise
    wire ovc_trip = ctrl3_r[ccr_pkg::C3_SRC_OVC] && ALERT_SRC.reverse_overcurrent_flag; // RQ7
    wire cmp_trip = ctrl3_r[ccr_pkg::C3_SRC_CMP] && ALERT_SRC.comparator_rise;          // RQ7
    wire deb_cond = (ctrl3_r[ccr_pkg::C3_SRC_BATABS] && ALERT_SRC.battery_absent_flag) ||
                    (ctrl3_r[ccr_pkg::C3_SRC_ADP] && !ALERT_SRC.adapter_present_flag); // RQ7

    // Debounce length by code
    wire [1:0] deb_code = ctrl3_r[ccr_pkg::C3_DEB_LO +: 2];
    always_comb begin
        case (deb_code) // RQ8
            2'h0:    deb_len = DEB_W'(ccr_pkg::DEB0_CYC);
            2'h1:    deb_len = DEB_W'(ccr_pkg::DEB1_CYC);
            2'h2:    deb_len = DEB_W'(ccr_pkg::DEB2_CYC);
            default: deb_len = DEB_W'(ccr_pkg::DEB3_CYC);
        endcase
    end

    // Debounce counter restarts whenever the condition drops
    wire deb_done = deb_cond && (deb_cnt_r >= deb_len - DEB_W'(1));
    assign deb_cnt_nxt = !deb_cond ? '0 : deb_done ? deb_cnt_r : deb_cnt_r + DEB_W'(1);
    wire trip = ovc_trip || cmp_trip || deb_done;

    // Alert: trip wins over clear; auto mode follows trip
    always_comb begin
        if (trip) alert_nxt = 1'b1;
        else if (wr_clear) alert_nxt = 1'b0; // RQ9
        else if (ctrl4_r[ccr_pkg::C4_LATCH]) alert_nxt = alert_r; // RQ10
        else alert_nxt = 1'b0; // RQ10
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            deb_cnt_r <= '0;
            alert_r   <= 1'b0;
        end else begin
            deb_cnt_r <= DIG_RESET ? '0 : deb_cnt_nxt;
            alert_r   <= DIG_RESET ? 1'b0 : alert_nxt;
        end
    end
    assign PROCESSOR_HOT_ALERT_N = ~alert_r;

    // Field decode to analog controls
    always_comb begin
        CTRL.dither_sel                     = ctrl3_r[ccr_pkg::C3_DITHER_LO +: 2]; // RQ1
        CTRL.adapter_node_sink_en           = ctrl3_r[ccr_pkg::C3_ADP_DIS]; // RQ2
        CTRL.system_rail_sink_en            = ctrl3_r[ccr_pkg::C3_SYS_SINK]; // RQ3
        CTRL.battery_switch_gate_hiz        = ctrl3_r[ccr_pkg::C3_GATE_TRI]; // RQ4
        CTRL.t3_short                       = ctrl3_r[ccr_pkg::C3_T3_SHORT]; // RQ5
        CTRL.t2_dcm_normal                  = ctrl3_r[ccr_pkg::C3_T2_NORMAL]; // RQ6
        CTRL.comp_res_sel                   = ctrl5_r[ccr_pkg::C5_COMP_LO +: 2]; // RQ11
        CTRL.battery_switch_gate_force      = ctrl5_r[ccr_pkg::C5_FORCE_GATE]; // RQ12
        CTRL.reverse_reg_en                 = ctrl5_r[ccr_pkg::C5_REV_REG]; // RQ13
        CTRL.second_level_adapter_limit_sel = ctrl5_r[ccr_pkg::C5_T2_LO +: 3]; // RQ14
        CTRL.first_level_adapter_limit_sel  = ctrl5_r[ccr_pkg::C5_T1_LO +: 3]; // RQ15
        CTRL.system_rail_good_cmp_en        = !ctrl5_r[ccr_pkg::C5_CMP_DIS]; // RQ16
        CTRL.system_rail_good_src_en        = !ctrl5_r[ccr_pkg::C5_SRC_DIS]; // RQ17
        CTRL.pin_sel_comparator             = ctrl5_r[ccr_pkg::C5_PIN_SEL]; // RQ18
        CTRL.overvoltage_prot_en            = !ctrl5_r[ccr_pkg::C5_OV_DIS]; // RQ19
    end
endmodule
`default_nettype wire

/* tb/ccr_regs_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module ccr_regs_assertions (
    // Clock and reset
    input wire logic                CLK,
    input wire logic                RESETN,
    // Register port
    input wire logic                REG_WR,
    input wire logic                REG_RD,
    input wire logic [7:0]          REG_ADDR,
    input wire logic [15:0]         REG_WDATA,
    input wire logic [15:0]         REG_RDATA,
    input wire logic                REG_HIT,
    input wire logic                DIG_RESET,
    // Alert and controls
    input wire ccr_pkg::ccr_flags_t ALERT_SRC,
    input wire logic                PROCESSOR_HOT_ALERT_N,
    input wire ccr_pkg::ccr_ctrl_t  CTRL
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // Writes that are not overridden by a digital reset
    sequence wr3; REG_WR && !DIG_RESET && REG_ADDR == 8'h4c; endsequence
    sequence wr5; REG_WR && !DIG_RESET && REG_ADDR == 8'h38; endsequence
    a_dither_field: assert property (wr3 |=> CTRL.dither_sel == $past(REG_WDATA[15:14]))
        else $error("dither field wrong");
    a_sink_enables: assert property (wr3 |=> {CTRL.adapter_node_sink_en,
        CTRL.system_rail_sink_en} == $past(REG_WDATA[13:12])) else $error("sink bits wrong");
    a_gate_timing: assert property (wr3 |=> {CTRL.battery_switch_gate_hiz,
        CTRL.t3_short, CTRL.t2_dcm_normal} == $past(REG_WDATA[11:9]))
        else $error("gate or timing bits wrong");
    a_comp_gate: assert property (wr5 |=> {CTRL.comp_res_sel,
        CTRL.battery_switch_gate_force} == $past(REG_WDATA[15:13])) else $error("comp wrong");
    a_limit_times: assert property (wr5 |=> {CTRL.reverse_reg_en,
        CTRL.second_level_adapter_limit_sel, CTRL.first_level_adapter_limit_sel}
        == $past({REG_WDATA[11:8], REG_WDATA[2:0]})) else $error("limit times wrong");
    a_rail_helpers: assert property (wr5 |=> {CTRL[3:0]}
        == $past({~REG_WDATA[7:6], REG_WDATA[5], ~REG_WDATA[4]})) else $error("helpers wrong");
    a_unmapped_zero: assert property (REG_RD && !REG_HIT |=> REG_RDATA == 16'h0000)
        else $error("unmapped read not zero");
    a_dig_defaults: assert property (DIG_RESET |=> CTRL == 21'h00000d)
        else $error("defaults not restored");
    a_hit_decode: assert property (REG_WR || REG_RD |-> REG_HIT
        == (REG_ADDR inside {8'h38, 8'h4c, 8'h4e})) else $error("hit decode wrong");
endmodule
`default_nettype wire

/* tb/ccr_host.sv */
`timescale 1ns/10ps
`default_nettype none
module ccr_host (
    // Clock
    input  wire logic        clk,
    // Requests toward the device
    output var  logic        wr,
    output var  logic        rd,
    output var  logic [7:0]  addr,
    output var  logic [15:0] wdata,
    // Read answer
    input  wire logic [15:0] rdata
);
    initial begin
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 16'h0000;
    end
    // One edge of strobe, then an idle edge so strobes never merge
    task automatic put(input logic [7:0] a, input logic [15:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        wdata <= ~d;
        @(posedge clk);
    endtask
    // Data is registered on the edge that takes the strobe, read one edge later
    task automatic get(input logic [7:0] a, output logic [15:0] d);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask
endmodule
`default_nettype wire

/* tb/ccr_regs_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module ccr_regs_tb;
    logic                clk = 1'b0;
    logic                resetn = 1'b0;
    logic                dig_reset = 1'b0;
    logic                wr, rd, hit, alert_n;
    logic [7:0]          addr;
    logic [15:0]         wdata, rdata, got, w;
    ccr_pkg::ccr_flags_t src = '0;
    ccr_pkg::ccr_ctrl_t  ctrl;
    int                  num_errors = 0;
    int                  samples_checked = 0;
    int                  mdl [3] = '{0, 0, 0};
    int                  deb [4] = '{200, 2500, 12500, 25000};
    logic [7:0]          ofs [3] = '{8'h38, 8'h4c, 8'h4e};
    logic [15:0]         msk [3] = '{16'heff7, 16'hfefc, 16'h0001};
    always #5 clk = ~clk;
    ccr_regs #(.DEB_W(16)) ccr_regs_inst (.CLK(clk), .RESETN(resetn), .REG_WR(wr),
        .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_HIT(hit),
        .DIG_RESET(dig_reset), .ALERT_SRC(src), .PROCESSOR_HOT_ALERT_N(alert_n), .CTRL(ctrl));
    ccr_host ccr_host_inst (.clk(clk), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata),
        .rdata(rdata));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic rdchk(input int i);
        ccr_host_inst.get(ofs[i], got);
        chk("readback", mdl[i][15:0], got);
    endtask
    // Pin sampled at an edge, before that edge's updates land
    task automatic alert(input logic e, input int n);
        repeat (n) @(posedge clk);
        chk("alert", {15'h0000, e}, {15'h0000, alert_n});
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Whole run is about 41k cycles
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        end_sim;
    end
    initial begin
        void'($urandom(32'h5ffe5766));
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 3; i++) rdchk(i);
        ccr_host_inst.get(8'h37, got);
        chk("unmapped", 16'h0000, got);
        $display("reset test done");
        // Random words; bits outside the fields must drop
        for (int n = 0; n < 8; n++) begin
            for (int i = 0; i < 3; i++) begin
                w = 16'($urandom);
                mdl[i] = w & msk[i];
                ccr_host_inst.put(ofs[i], w);
                rdchk(i);
            end
        end
        $display("random test done");
        ccr_host_inst.put(8'h4c, 16'h0080);
        ccr_host_inst.put(8'h4e, 16'h0000);
        src.reverse_overcurrent_flag <= 1'b1;
        alert(1'b0, 3);
        src.reverse_overcurrent_flag <= 1'b0;
        alert(1'b1, 3);
        ccr_host_inst.put(8'h4e, 16'h0001);
        src.reverse_overcurrent_flag <= 1'b1;
        alert(1'b0, 3);
        src.reverse_overcurrent_flag <= 1'b0;
        alert(1'b0, 10);
        ccr_host_inst.put(8'h4e, 16'h0003);
        alert(1'b1, 3);
        mdl[2] = 1;
        rdchk(2);
        ccr_host_inst.put(8'h4e, 16'h0000);
        $display("latch test done");
        // Adapter drop must persist the whole debounce before tripping
        foreach (deb[k]) begin
            src.adapter_present_flag <= 1'b1;
            ccr_host_inst.put(8'h4c, {12'h002, k[1:0], 2'b00});
            src.adapter_present_flag <= 1'b0;
            alert(1'b1, deb[k] - 10);
            alert(1'b0, 20);
        end
        $display("debounce test done");
        // Comparator source trips at once; battery-absent after the shortest debounce
        ccr_host_inst.put(8'h4c, 16'h0010);
        src.comparator_rise <= 1'b1;
        alert(1'b0, 3);
        src.comparator_rise <= 1'b0;
        alert(1'b1, 3);
        ccr_host_inst.put(8'h4c, 16'h0040);
        src.battery_absent_flag <= 1'b1;
        alert(1'b1, 150);
        alert(1'b0, 60);
        src.battery_absent_flag <= 1'b0;
        alert(1'b1, 3);
        $display("source test done");
        dig_reset <= 1'b1;
        @(posedge clk);
        dig_reset <= 1'b0;
        mdl = '{0, 0, 0};
        for (int i = 0; i < 3; i++) rdchk(i);
        $display("digital reset test done");
        end_sim;
    end
endmodule
bind ccr_regs ccr_regs_assertions ccr_regs_assertions_inst (.*);
`default_nettype wire
